// ---- bench/subx_datapath_tb.sv ----
/*
  bench for the subtract / swap / exchange datapath: reference model and scenarios.
  assumes one core clock; the bench supplies operands as the core would.
*/
`timescale 1ns/1ns
module subtract_swap_exchange_datapath_tb_top;
  import subx_pkg::*;
  logic core_clk_i = 1'b0, rst_i = 1'b1, exec_i = 1'b0;
  logic [7:0] op = 8'h00, sb = 8'h00, rv = 8'h00, pv = 8'h00, mv = 8'h00, dv = 8'h00;
  op_kind_t kind;
  logic [7:0] acc, program_status_word, maddr, wdata, e_acc, e_psw, e_addr, e_wd;
  logic done, mwe, rwe;
  logic [2:0] idx, e_idx;
  int bad_count = 0, checks = 0;
  always #20 core_clk_i = ~core_clk_i;
  subtract_swap_exchange_datapath DUT (.core_clk_i(core_clk_i), .rst_i(rst_i), .exec_i(exec_i),
    .opcode_i(op), .second_byte_i(sb), .reg_value_i(rv), .pointer_value_i(pv), .mem_value_i(mv),
    .direct_value_i(dv), .op_kind_o(kind), .accumulator_o(acc), .program_status_word_o(program_status_word),
    .done_o(done), .mem_we_o(mwe), .mem_addr_o(maddr), .mem_wdata_o(wdata), .reg_we_o(rwe),
    .reg_idx_o(idx));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic final_report;
    if (bad_count == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : final_report
  task automatic do_reset(input int n);
    rst_i = 1'b1;
    exec_i = 1'b0;
    repeat (n) @(negedge core_clk_i);
    chk("rst_data", {acc, program_status_word, maddr, wdata}, 32'h0000_0000);
    chk("rst_ctl", {kind, idx, done, mwe, rwe}, {OP_NONE, 6'h00});
    rst_i = 1'b0;
    {e_acc, e_psw, e_addr, e_wd, e_idx} = '0;
  endtask : do_reset
  // drives one op for one edge and leaves exec high, so calls run back to back
  task automatic issue(input logic [7:0] o, s, r, p, m, d);
    logic [8:0] dif;
    logic [7:0] b;
    logic h;
    logic c;
    op_kind_t k;
    {op, sb, rv, pv, mv, dv} = {o, s, r, p, m, d};
    exec_i = 1'b1;
    c = e_psw[7];
    case (o) inside
      [8'h96:8'h97]: k = OP_SUB_IND;
      [8'h98:8'h9F]: k = OP_SUB_REG;
      8'h95: k = OP_SUB_DIR;
      8'h94: k = OP_SUB_IMM;
      8'hC4: k = OP_SWAP;
      [8'hC6:8'hC7]: k = OP_XCH_IND;
      [8'hC8:8'hCF]: k = OP_XCH_REG;
      8'hC5: k = OP_XCH_DIR;
      default: k = OP_NONE;
    endcase
    b = (k[1] | k[6]) ? m : (k[2] | k[7]) ? r : (k[3] | k[8]) ? d : s;
    @(negedge core_clk_i);
    if (|k[4:1]) begin
      dif = {1'b0, e_acc} - {1'b0, b} - c;
      h = {1'b0, e_acc[3:0]} < ({1'b0, b[3:0]} + c);
      e_psw[7:6] = {dif[8], h};
      e_psw[2] = (e_acc[7] != b[7]) && (dif[7] != e_acc[7]);
      e_acc = dif[7:0];
    end
    if (k[5]) e_acc = {e_acc[3:0], e_acc[7:4]};
    if (|k[8:6]) begin
      e_wd = e_acc;
      e_acc = b;
    end
    if (k[6]) e_addr = p;
    if (k[8]) e_addr = s;
    if (k[2] | k[7]) e_idx = o[2:0];
    if (k != OP_NONE) e_psw[0] = ^e_acc;
    chk("acc", acc, e_acc);
    chk("psw", program_status_word, e_psw);
    chk("kind", kind, k);
    chk("pulses", {done, mwe, rwe}, {k != OP_NONE, k[6] | k[8], k[7]});
    chk("wback", {maddr, wdata, idx}, {e_addr, e_wd, e_idx});
  endtask : issue
  task automatic idle;
    exec_i = 1'b0;
    @(negedge core_clk_i);
    chk("idle", {done, mwe, rwe}, 32'h0000_0000);
  endtask : idle
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_sub;
    issue(8'h94, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00);
    issue(8'hCE, 8'h00, 8'h76, 8'h00, 8'h00, 8'h00);
    issue(8'h9E, 8'h00, 8'h85, 8'h00, 8'h00, 8'h00);
    issue(8'h97, 8'h00, 8'h00, 8'h1C, 8'h62, 8'h00);
    issue(8'h95, 8'h32, 8'h00, 8'h00, 8'h00, 8'h53);
    for (int i = 0; i < 8; i++) issue(8'(8'h98 + i), 8'h00, 8'(8'h1F * i), 8'h00, 8'h00, 8'h00);
    idle();
  endtask : t_sub
  task automatic t_swap;
    issue(8'hC5, 8'h37, 8'h00, 8'h00, 8'h00, 8'hD0);
    issue(8'hC4, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00);
    issue(8'hC4, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00);
    idle();
  endtask : t_swap
  task automatic t_xch;
    issue(8'hC6, 8'h00, 8'h00, 8'h52, 8'h1D, 8'h00);
    for (int i = 0; i < 8; i++) issue(8'(8'hC8 + i), 8'h00, 8'(8'hA0 + i), 8'h00, 8'h00, 8'h00);
    issue(8'hC5, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00);
    issue(8'hC7, 8'h00, 8'h00, 8'h00, 8'h81, 8'h00);
    idle();
  endtask : t_xch
  task automatic t_refuse;
    issue(8'hD6, 8'h44, 8'h55, 8'h66, 8'h77, 8'h88);
    issue(8'h93, 8'h12, 8'h34, 8'h56, 8'h78, 8'h9A);
    issue(8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00);
    idle();
    issue(8'h96, 8'h00, 8'h00, 8'h20, 8'h7F, 8'h00);
    do_reset(2);
  endtask : t_refuse
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    do_reset(12);
    t_sub();
    t_swap();
    t_xch();
    t_refuse();
    t_sub();
    final_report();
  end
  initial begin
    repeat (3000) @(posedge core_clk_i);
    bad_count++;
    final_report();
  end
endmodule : subtract_swap_exchange_datapath_tb_top

// ---- core/subtract_swap_exchange_datapath.sv ----
/*
  one-cycle execution slice: subtract with borrow, nibble swap and accumulator exchange.
  assumes the decoder presents opcode, second byte and operand values for one cycle with
  exec_i; the core applies the mem/reg write-back pulses it receives the next cycle.
*/
`timescale 1ns/1ns
`include "subx_consts.svh"

module subtract_swap_exchange_datapath #(
  parameter int DATA_W = 8
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic exec_i,
  input wire logic [7:0] opcode_i,
  input wire logic [7:0] second_byte_i,
  input wire logic [DATA_W-1:0] reg_value_i,
  input wire logic [DATA_W-1:0] pointer_value_i,
  input wire logic [DATA_W-1:0] mem_value_i,
  input wire logic [DATA_W-1:0] direct_value_i,
  output subx_pkg::op_kind_t op_kind_o,
  output logic [DATA_W-1:0] accumulator_o,
  output logic [7:0] program_status_word_o,
  output logic done_o,
  output logic mem_we_o,
  output logic [7:0] mem_addr_o,
  output logic [DATA_W-1:0] mem_wdata_o,
  output logic reg_we_o,
  output logic [2:0] reg_idx_o
);
  import subx_pkg::*;

  if (DATA_W != 8) begin : g_width_check
    $error("datapath is byte wide only");
  end

  // one-hot kind of an opcode, OP_NONE for anything this slice does not run
  function automatic op_kind_t decode(input logic [7:0] opc);
    if (opc == `OPC_SUB_IMM) decode = OP_SUB_IMM;
    else if (opc == `OPC_SUB_DIR) decode = OP_SUB_DIR;
    else if (opc[7:1] == `OPC_SUB_IND) decode = OP_SUB_IND;
    else if (opc[7:3] == `OPC_SUB_REG) decode = OP_SUB_REG;
    else if (opc == `OPC_SWAP) decode = OP_SWAP;
    else if (opc == `OPC_XCH_DIR) decode = OP_XCH_DIR;
    else if (opc[7:1] == `OPC_XCH_IND) decode = OP_XCH_IND;
    else if (opc[7:3] == `OPC_XCH_REG) decode = OP_XCH_REG;
    else decode = OP_NONE;
  endfunction : decode

  ////////////////////////////////////////////////////////////////////////////////
  logic [7:0] acc;
  logic [7:0] program_status_word;
  op_kind_t kind;
  logic done;
  logic mem_we;
  logic [7:0] mem_addr;
  logic [7:0] mem_wdata;
  logic reg_we;
  logic [2:0] reg_idx;
  logic [7:0] next_acc;
  logic [7:0] next_psw;
  op_kind_t next_kind;
  logic next_done;
  logic next_mem_we;
  logic [7:0] next_mem_addr;
  logic [7:0] next_mem_wdata;
  logic next_reg_we;
  logic [2:0] next_reg_idx;
  logic [7:0] operand;
  logic [8:0] diff;
  logic [4:0] low_diff;
  op_kind_t cur;

  always_comb begin
    cur = exec_i ? decode(opcode_i) : OP_NONE;
    next_acc = acc;
    next_psw = program_status_word;
    next_kind = cur;
    next_done = exec_i && (cur != OP_NONE);
    next_mem_we = 1'b0;
    next_mem_addr = mem_addr;
    next_mem_wdata = mem_wdata;
    next_reg_we = 1'b0;
    next_reg_idx = reg_idx;
    operand = 8'h00;
    case (cur)
      OP_SUB_IND: operand = mem_value_i;
      OP_SUB_REG: operand = reg_value_i;
      OP_SUB_DIR: operand = direct_value_i;
      OP_SUB_IMM: operand = second_byte_i;
      default: operand = 8'h00;
    endcase
    // nine and five bit differences give the borrows out of bit 7 and bit 3
    diff = {1'b0, acc} - {1'b0, operand} - {8'h00, program_status_word[`FLAG_CARRY]};
    low_diff = {1'b0, acc[3:0]} - {1'b0, operand[3:0]} - {4'h0, program_status_word[`FLAG_CARRY]};
    case (cur)
      OP_SUB_IND, OP_SUB_REG, OP_SUB_DIR, OP_SUB_IMM: begin
        next_acc = diff[7:0];
        next_psw[`FLAG_CARRY] = diff[8];
        next_psw[`FLAG_HALF] = low_diff[4];
        next_psw[`FLAG_OVF] = (acc[7] != operand[7]) && (diff[7] != acc[7]);
      end
      OP_SWAP: next_acc = {acc[3:0], acc[7:4]};
      OP_XCH_IND: begin
        next_acc = mem_value_i;
        next_mem_we = 1'b1;
        next_mem_addr = pointer_value_i;
        next_mem_wdata = acc;
      end
      OP_XCH_REG: begin
        next_acc = reg_value_i;
        next_reg_we = 1'b1;
        next_reg_idx = opcode_i[2:0];
        next_mem_wdata = acc;
      end
      OP_XCH_DIR: begin
        next_acc = direct_value_i;
        next_mem_we = 1'b1;
        next_mem_addr = second_byte_i;
        next_mem_wdata = acc;
      end
      default: next_acc = acc;
    endcase
    if (cur == OP_SUB_REG) next_reg_idx = opcode_i[2:0];
    next_psw[`FLAG_PARITY] = ^next_acc;
  end

  // write-back data loads on every exchange, the address only on an indirect or direct exchange, the index on a register exchange and also on a register subtract
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      acc <= `ACC_RESET;
      program_status_word <= `PSW_RESET;
      kind <= OP_NONE;
      done <= 1'b0;
      mem_we <= 1'b0;
      mem_addr <= 8'h00;
      mem_wdata <= 8'h00;
      reg_we <= 1'b0;
      reg_idx <= 3'h0;
    end else begin
      acc <= next_acc;
      program_status_word <= next_psw;
      kind <= next_kind;
      done <= next_done;
      mem_we <= next_mem_we;
      mem_addr <= next_mem_addr;
      mem_wdata <= next_mem_wdata;
      reg_we <= next_reg_we;
      reg_idx <= next_reg_idx;
    end
  end

  assign accumulator_o = acc;
  assign program_status_word_o = program_status_word;
  assign op_kind_o = kind;
  assign done_o = done;
  assign mem_we_o = mem_we;
  assign mem_addr_o = mem_addr;
  assign mem_wdata_o = mem_wdata;
  assign reg_we_o = reg_we;
  assign reg_idx_o = reg_idx;

  ////////////////////////////////////////////////////////////////////////////////
  a_sub_ind_result: assert property (@(posedge core_clk_i) disable iff (rst_i)
    exec_i && opcode_i[7:1] == `OPC_SUB_IND |=>
    acc == 8'($past(acc) - $past(mem_value_i) - {7'h00, $past(program_status_word[`FLAG_CARRY])}))
    else $error("indirect subtract result wrong");
  a_sub_reg_result: assert property (@(posedge core_clk_i) disable iff (rst_i)
    exec_i && opcode_i[7:3] == `OPC_SUB_REG |=>
    acc == 8'($past(acc) - $past(reg_value_i) - {7'h00, $past(program_status_word[`FLAG_CARRY])}) && reg_idx == $past(opcode_i[2:0]))
    else $error("register subtract result wrong");
  a_sub_dir_result: assert property (@(posedge core_clk_i) disable iff (rst_i)
    exec_i && opcode_i == `OPC_SUB_DIR |=>
    acc == 8'($past(acc) - $past(direct_value_i) - {7'h00, $past(program_status_word[`FLAG_CARRY])}))
    else $error("direct subtract result wrong");
  a_swap_nibbles: assert property (@(posedge core_clk_i) disable iff (rst_i)
    exec_i && opcode_i == `OPC_SWAP |=> acc == {$past(acc[3:0]), $past(acc[7:4])} && done)
    else $error("nibble swap wrong");
  a_xch_ind_pair: assert property (@(posedge core_clk_i) disable iff (rst_i)
    exec_i && opcode_i[7:1] == `OPC_XCH_IND |=>
    acc == $past(mem_value_i) && mem_we && mem_wdata == $past(acc) && mem_addr == $past(pointer_value_i))
    else $error("indirect exchange wrong");
  a_xch_reg_pair: assert property (@(posedge core_clk_i) disable iff (rst_i)
    exec_i && opcode_i[7:3] == `OPC_XCH_REG |=>
    acc == $past(reg_value_i) && reg_we && mem_wdata == $past(acc) && reg_idx == $past(opcode_i[2:0]))
    else $error("register exchange wrong");
  a_xch_dir_pair: assert property (@(posedge core_clk_i) disable iff (rst_i)
    exec_i && opcode_i == `OPC_XCH_DIR |=>
    acc == $past(direct_value_i) && mem_we && mem_addr == $past(second_byte_i) && !reg_we)
    else $error("direct exchange wrong");
  a_sub_imm_result: assert property (@(posedge core_clk_i) disable iff (rst_i)
    exec_i && opcode_i == `OPC_SUB_IMM |=>
    acc == 8'($past(acc) - $past(second_byte_i) - {7'h00, $past(program_status_word[`FLAG_CARRY])}))
    else $error("immediate subtract result wrong");
  a_sub_flags: assert property (@(posedge core_clk_i) disable iff (rst_i)
    exec_i && decode(opcode_i) inside {OP_SUB_IND, OP_SUB_REG, OP_SUB_DIR, OP_SUB_IMM} |=>
    program_status_word[`FLAG_CARRY] == ({1'b0, $past(acc)} < {1'b0, $past(operand)} + {8'h00, $past(program_status_word[`FLAG_CARRY])})
    && program_status_word[`FLAG_PARITY] == ^acc)
    else $error("subtract flags wrong");
  a_keep_flags: assert property (@(posedge core_clk_i) disable iff (rst_i)
    exec_i && decode(opcode_i) inside {OP_SWAP, OP_XCH_IND, OP_XCH_REG, OP_XCH_DIR} |=>
    program_status_word[7:1] == $past(program_status_word[7:1]) && program_status_word[`FLAG_PARITY] == ^acc)
    else $error("swap or exchange disturbed flags");

  // borrow flags, write-back pulses and quiet cycles
  a_sub_half_ovf: assert property (@(posedge core_clk_i) disable iff (rst_i)
    exec_i && decode(opcode_i) inside {OP_SUB_IND, OP_SUB_REG, OP_SUB_DIR, OP_SUB_IMM} |=>
    program_status_word[`FLAG_HALF] == ({1'b0, $past(acc[3:0])} < {1'b0, $past(operand[3:0])} + {4'h0, $past(program_status_word[`FLAG_CARRY])})
    && program_status_word[`FLAG_OVF] == (($past(acc[7]) != $past(operand[7])) && (acc[7] != $past(acc[7]))))
    else $error("subtract half carry or overflow wrong");
  a_sub_no_write: assert property (@(posedge core_clk_i) disable iff (rst_i)
    exec_i && decode(opcode_i) inside {OP_SUB_IND, OP_SUB_REG, OP_SUB_DIR, OP_SUB_IMM, OP_SWAP} |=>
    done && !mem_we && !reg_we && program_status_word[5:3] == $past(program_status_word[5:3]) && program_status_word[1] == $past(program_status_word[1]))
    else $error("subtract or swap wrote back or touched control flags");
  a_refuse_quiet: assert property (@(posedge core_clk_i) disable iff (rst_i)
    !exec_i || decode(opcode_i) == OP_NONE |=>
    !done && !mem_we && !reg_we && acc == $past(acc) && program_status_word == $past(program_status_word))
    else $error("idle or unknown opcode changed state");
  a_write_with_done: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (mem_we || reg_we) |-> done && !(mem_we && reg_we))
    else $error("write pulse without a completed exchange");
endmodule : subtract_swap_exchange_datapath

// ---- core/subx_consts.svh ----
/*
  constants for the subtract / swap / exchange datapath: opcodes, flag positions, reset values.
  assumes inclusion by bare name from the package and the datapath module.
*/
`ifndef SUBX_CONSTS_SVH
`define SUBX_CONSTS_SVH

`define OPC_SUB_IMM 8'h94
`define OPC_SUB_DIR 8'h95
`define OPC_SUB_IND 7'h4B
`define OPC_SUB_REG 5'h13
`define OPC_SWAP 8'hC4
`define OPC_XCH_DIR 8'hC5
`define OPC_XCH_IND 7'h63
`define OPC_XCH_REG 5'h19

`define FLAG_CARRY 7
`define FLAG_HALF 6
`define FLAG_USER0 5
`define FLAG_BANK_HI 4
`define FLAG_BANK_LO 3
`define FLAG_OVF 2
`define FLAG_PARITY 0

`define ACC_RESET 8'h00
`define PSW_RESET 8'h00

`endif

// ---- core/subx_pkg.sv ----
/*
  types for the subtract / swap / exchange datapath.
  assumes subx_consts.svh is on the include path.
*/
package subx_pkg;
`include "subx_consts.svh"

  typedef enum logic [8:0] {
    OP_NONE = 9'b0_0000_0001,
    OP_SUB_IND = 9'b0_0000_0010,
    OP_SUB_REG = 9'b0_0000_0100,
    OP_SUB_DIR = 9'b0_0000_1000,
    OP_SUB_IMM = 9'b0_0001_0000,
    OP_SWAP = 9'b0_0010_0000,
    OP_XCH_IND = 9'b0_0100_0000,
    OP_XCH_REG = 9'b0_1000_0000,
    OP_XCH_DIR = 9'b1_0000_0000
  } op_kind_t;
endpackage : subx_pkg
